//--- common/pvit_pkg.sv
// package: register map, reset values and timing limits of the video source
package pvit_pkg;
  // register map of the controller's own AXI4-Lite slave (byte addresses)
  localparam logic [7:0] REG_CTRL_OFS = 8'h00;
  localparam logic [7:0] REG_HACT_OFS = 8'h04;
  localparam logic [7:0] REG_HSW_OFS = 8'h08;
  localparam logic [7:0] REG_HBP_OFS = 8'h0C;
  localparam logic [7:0] REG_HFP_OFS = 8'h10;
  localparam logic [7:0] REG_VACT_OFS = 8'h14;
  localparam logic [7:0] REG_VSW_OFS = 8'h18;
  localparam logic [7:0] REG_VBP_OFS = 8'h1C;
  localparam logic [7:0] REG_VFP_OFS = 8'h20;
  localparam logic [7:0] REG_VDLY_OFS = 8'h24;
  localparam logic [7:0] REG_STAT_OFS = 8'h28;
  localparam int CFG_N = 10;
  localparam int CFG_W = 12;
  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_DLY_OK_BIT = 1;
  localparam int STAT_FCNT_LSB = 16;
  // reset values, in table order from REG_CTRL_OFS upward
  localparam logic [CFG_W-1:0] RST_CTRL = 12'h000;
  localparam logic [CFG_W-1:0] RST_HACT = 12'h280;
  localparam logic [CFG_W-1:0] RST_HSW = 12'h010;
  localparam logic [CFG_W-1:0] RST_HBP = 12'h030;
  localparam logic [CFG_W-1:0] RST_HFP = 12'h010;
  localparam logic [CFG_W-1:0] RST_VACT = 12'h1E0;
  localparam logic [CFG_W-1:0] RST_VSW = 12'h002;
  localparam logic [CFG_W-1:0] RST_VBP = 12'h021;
  localparam logic [CFG_W-1:0] RST_VFP = 12'h00A;
  // device-side register: vertical sync line delay, and its reset value
  localparam logic [7:0] DEV_VSYNC_LINE_DELAY_OFS = 8'h23;
  localparam logic [CFG_W-1:0] RST_VDLY = 12'h005;
  // frame limits in lines
  localparam logic [CFG_W-1:0] VSW_MIN = 12'h001;
  localparam logic [CFG_W-1:0] VBP_MIN = 12'h002;
  localparam logic [CFG_W-1:0] VFP_MIN = 12'h001;
  localparam logic [CFG_W-1:0] VBLANK_MIN = 12'h00C;
  localparam logic [CFG_W-1:0] VDLY_LO_BASE = 12'h006;
  localparam logic [CFG_W-1:0] VDLY_HI_SUB = 12'h002;
  localparam logic [CFG_W-1:0] VDLY_MAX = 12'h00F;
  // line limits in pixel clocks
  localparam logic [CFG_W-1:0] HSW_MIN = 12'h004;
  localparam logic [CFG_W-1:0] HSW_MAX = 12'h080;
  localparam logic [CFG_W-1:0] HBP_MIN = 12'h004;
  localparam logic [CFG_W-1:0] HFP_MIN = 12'h008;
  // pixel clock: system clock divided down, inside the allowed range
  localparam int SYS_CLK_KHZ = 200000;
  localparam int PCLK_MIN_KHZ = 1000;
  localparam int PCLK_MAX_KHZ = 33500;
  localparam int PCLK_DIV = 8;
  localparam int PCLK_KHZ = SYS_CLK_KHZ / PCLK_DIV;
  localparam int PCLK_CW = 3;
  localparam logic [PCLK_CW-1:0] PCLK_LAST = 3'h7;
  localparam logic [PCLK_CW-1:0] PCLK_HALF = 3'h4;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    PVIT_IDLE = 2'b01,
    PVIT_RUN = 2'b10
  } pvit_state_t;
endpackage

//--- rtl/pvit_clkdiv.sv
// pixel clock divider: drives the pixel clock and flags its falling edge
`timescale 1ns/1ps
module pvit_clkdiv
  import pvit_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  output logic o_pclk,
  output logic o_fall_tick
);
  logic [PCLK_CW-1:0] cnt_r;
  logic [PCLK_CW-1:0] cnt_nxt;
  logic pclk_r;
  logic pclk_nxt;

  always_comb begin
    cnt_nxt = cnt_r + 3'h1;
    pclk_nxt = (cnt_nxt >= PCLK_HALF);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt_r <= 3'h0;
      pclk_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      pclk_r <= pclk_nxt;
    end
  end

  assign o_pclk = pclk_r;
  // pulse in the cycle before the pixel clock falls; outputs change with the fall
  assign o_fall_tick = (cnt_r == PCLK_LAST);
endmodule

//--- rtl/pvit_pixsrc.sv
// pixel pattern source: registered 24-bit pixel word for each active pixel
`timescale 1ns/1ps
module pvit_pixsrc
  import pvit_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire logic i_valid,
  input wire logic [CFG_W-1:0] i_hpos,
  input wire logic [CFG_W-1:0] i_vpos,
  input wire logic [7:0] i_frame,
  output logic [23:0] o_pixel_bus
);
  logic [23:0] data_r;
  logic [23:0] data_nxt;

  always_comb begin
    data_nxt = data_r;
    if (i_tick) begin
      data_nxt = i_valid ? {i_frame, i_vpos[7:0], i_hpos[7:0]} : 24'h000000;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      data_r <= 24'h000000;
    end else begin
      data_r <= data_nxt;
    end
  end

  assign o_pixel_bus = data_r;
endmodule

//--- rtl/pvit_top.sv
// parallel video source: AXI4-Lite configured timing generator driving a pixel port
// Operation
// - frame sync high at least one line
// - two lines frame sync to first line
// - one line last line to frame sync
// - vertical blanking at least twelve lines
// - line sync high 4 to 128 clocks
// - four clocks line sync to valid
// - eight clocks valid end to sync
// - line delay checked against porch window, flagged in status bit 1
// - horizontal blanking covers both porches
// - pixel clock between 1 and 33.5 MHz
`timescale 1ns/1ps
module pvit_top
  import pvit_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic o_pclk,
  output logic o_vsync,
  output logic o_hsync,
  output logic o_pixel_valid_in,
  output logic [23:0] o_pixel_bus_in
);
  localparam logic [CFG_W-1:0] CFG_RST [CFG_N] = '{RST_CTRL, RST_HACT, RST_HSW, RST_HBP,
    RST_HFP, RST_VACT, RST_VSW, RST_VBP, RST_VFP, RST_VDLY};

  // ---------------- AXI4-Lite slave ----------------
  logic [CFG_W-1:0] cfg_r [CFG_N];
  logic [CFG_W-1:0] cfg_nxt [CFG_N];
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] stat_w;
  logic [7:0] wr_addr;
  logic [31:0] wr_data, wr_full;
  logic [3:0] wr_strb;
  logic aw_fire, w_fire, do_wr, ar_fire;
  logic [3:0] wr_idx, rd_idx;

  assign o_s_axi_awready = !aw_held_r && !bvalid_r;
  assign o_s_axi_wready = !w_held_r && !bvalid_r;
  assign o_s_axi_arready = !rvalid_r;
  assign aw_fire = i_s_axi_awvalid && o_s_axi_awready;
  assign w_fire = i_s_axi_wvalid && o_s_axi_wready;
  assign ar_fire = i_s_axi_arvalid && o_s_axi_arready;
  assign wr_addr = aw_held_r ? aw_addr_r : i_s_axi_awaddr;
  assign wr_data = w_held_r ? w_data_r : i_s_axi_wdata;
  assign wr_strb = w_held_r ? w_strb_r : i_s_axi_wstrb;
  assign do_wr = (aw_held_r || aw_fire) && (w_held_r || w_fire);
  assign wr_idx = wr_addr[5:2];
  assign rd_idx = i_s_axi_araddr[5:2];

  always_comb begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt = w_held_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r && !i_s_axi_bready;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r && !i_s_axi_rready;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    cfg_nxt = cfg_r;
    wr_full = 32'h00000000;
    if (aw_fire) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = i_s_axi_awaddr;
    end
    if (w_fire) begin
      w_held_nxt = 1'b1;
      w_data_nxt = i_s_axi_wdata;
      w_strb_nxt = i_s_axi_wstrb;
    end
    if (do_wr) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = AXI_SLVERR;
      if (wr_addr[1:0] == 2'h0 && wr_addr < REG_STAT_OFS) begin
        bresp_nxt = AXI_OKAY;
        wr_full = {20'h00000, cfg_r[wr_idx]};
        for (int b = 0; b < 4; b++) begin
          if (wr_strb[b]) begin
            wr_full[8*b +: 8] = wr_data[8*b +: 8];
          end
        end
        cfg_nxt[wr_idx] = wr_full[CFG_W-1:0];
      end
    end
    if (ar_fire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = AXI_OKAY;
      rdata_nxt = 32'h00000000;
      if (i_s_axi_araddr == REG_STAT_OFS) begin
        rdata_nxt = stat_w;
      end else if (i_s_axi_araddr[1:0] == 2'h0 && i_s_axi_araddr < REG_STAT_OFS) begin
        rdata_nxt = {20'h00000, cfg_r[rd_idx]};
      end else begin
        rresp_nxt = AXI_SLVERR;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_held_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= AXI_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= AXI_OKAY;
      rdata_r <= 32'h00000000;
      cfg_r <= CFG_RST;
    end else begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r <= w_held_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  assign o_s_axi_bvalid = bvalid_r;
  assign o_s_axi_bresp = bresp_r;
  assign o_s_axi_rvalid = rvalid_r;
  assign o_s_axi_rresp = rresp_r;
  assign o_s_axi_rdata = rdata_r;

  // ---------------- effective timing, forced into the legal window ----------------
  logic [CFG_W-1:0] hsw_e, hbp_e, hfp_e, vsw_e, vbp_e, vfp_e, dly_lo, dly_hi;
  logic dly_ok;

  always_comb begin
    hsw_e = cfg_r[2];
    if (hsw_e < HSW_MIN) hsw_e = HSW_MIN;
    if (hsw_e > HSW_MAX) hsw_e = HSW_MAX;
    hbp_e = (cfg_r[3] < HBP_MIN) ? HBP_MIN : cfg_r[3];
    if (hbp_e < hsw_e) hbp_e = hsw_e;
    hfp_e = (cfg_r[4] < HFP_MIN) ? HFP_MIN : cfg_r[4];
    vsw_e = (cfg_r[6] < VSW_MIN) ? VSW_MIN : cfg_r[6];
    vbp_e = (cfg_r[7] < VBP_MIN) ? VBP_MIN : cfg_r[7];
    if (vbp_e < vsw_e) vbp_e = vsw_e;
    vfp_e = (cfg_r[8] < VFP_MIN) ? VFP_MIN : cfg_r[8];
    if (vbp_e < VBLANK_MIN && vfp_e < VBLANK_MIN - vbp_e) begin
      vfp_e = VBLANK_MIN - vbp_e;
    end
    // window in which the device's line delay setting must lie
    dly_lo = (vfp_e >= VDLY_LO_BASE) ? 12'h000 : VDLY_LO_BASE - vfp_e;
    dly_hi = vbp_e - VDLY_HI_SUB;
    if (dly_hi > VDLY_MAX) dly_hi = VDLY_MAX;
    dly_ok = (cfg_r[9] >= dly_lo) && (cfg_r[9] <= dly_hi);
  end

  // ---------------- timing generator ----------------
  logic tick;
  pvit_clkdiv u_clkdiv (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .o_pclk(o_pclk),
    .o_fall_tick(tick)
  );

  pvit_state_t state_r, state_nxt;
  logic [CFG_W-1:0] hcnt_r, hcnt_nxt, vcnt_r, vcnt_nxt;
  logic [CFG_W-1:0] hsw_s, hbp_s, hact_s, hfp_s, vsw_s, vbp_s, vact_s, vfp_s;
  logic [CFG_W-1:0] hsw_sn, hbp_sn, hact_sn, hfp_sn, vsw_sn, vbp_sn, vact_sn, vfp_sn;
  logic [CFG_W-1:0] htot, vtot;
  logic hs_r, hs_nxt, vs_r, vs_nxt, de_r, de_nxt;
  logic [15:0] fcnt_r, fcnt_nxt;
  logic load;

  assign htot = hbp_s + hact_s + hfp_s;
  assign vtot = vbp_s + vact_s + vfp_s;

  always_comb begin
    state_nxt = state_r;
    hcnt_nxt = hcnt_r;
    vcnt_nxt = vcnt_r;
    fcnt_nxt = fcnt_r;
    load = 1'b0;
    case (state_r)
      PVIT_IDLE: begin
        if (tick && cfg_r[0][CTRL_EN_BIT]) begin
          state_nxt = PVIT_RUN;
          hcnt_nxt = 12'h000;
          vcnt_nxt = 12'h000;
          load = 1'b1;
        end
      end
      PVIT_RUN: begin
        if (tick) begin
          hcnt_nxt = hcnt_r + 12'h001;
          if (hcnt_r == htot - 12'h001) begin
            hcnt_nxt = 12'h000;
            vcnt_nxt = vcnt_r + 12'h001;
            if (vcnt_r == vtot - 12'h001) begin
              vcnt_nxt = 12'h000;
              fcnt_nxt = fcnt_r + 16'h0001;
              load = cfg_r[0][CTRL_EN_BIT];
              if (!cfg_r[0][CTRL_EN_BIT]) state_nxt = PVIT_IDLE;
            end
          end
        end
      end
      default: state_nxt = PVIT_IDLE;
    endcase
    // timing is taken over only at a frame boundary so a frame never mixes settings
    hsw_sn = load ? hsw_e : hsw_s;
    hbp_sn = load ? hbp_e : hbp_s;
    hact_sn = load ? cfg_r[1] : hact_s;
    hfp_sn = load ? hfp_e : hfp_s;
    vsw_sn = load ? vsw_e : vsw_s;
    vbp_sn = load ? vbp_e : vbp_s;
    vact_sn = load ? cfg_r[5] : vact_s;
    vfp_sn = load ? vfp_e : vfp_s;
    hs_nxt = hs_r;
    vs_nxt = vs_r;
    de_nxt = de_r;
    if (tick) begin
      hs_nxt = (state_nxt == PVIT_RUN) && (hcnt_nxt < hsw_sn);
      vs_nxt = (state_nxt == PVIT_RUN) && (vcnt_nxt < vsw_sn);
      de_nxt = (state_nxt == PVIT_RUN) && (hcnt_nxt >= hbp_sn) &&
        (hcnt_nxt < hbp_sn + hact_sn) && (vcnt_nxt >= vbp_sn) &&
        (vcnt_nxt < vbp_sn + vact_sn);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_r <= PVIT_IDLE;
      hcnt_r <= 12'h000;
      vcnt_r <= 12'h000;
      fcnt_r <= 16'h0000;
      hs_r <= 1'b0;
      vs_r <= 1'b0;
      de_r <= 1'b0;
      {hsw_s, hbp_s, hact_s, hfp_s} <= {RST_HSW, RST_HBP, RST_HACT, RST_HFP};
      {vsw_s, vbp_s, vact_s, vfp_s} <= {RST_VSW, RST_VBP, RST_VACT, RST_VFP};
    end else begin
      state_r <= state_nxt;
      hcnt_r <= hcnt_nxt;
      vcnt_r <= vcnt_nxt;
      fcnt_r <= fcnt_nxt;
      hs_r <= hs_nxt;
      vs_r <= vs_nxt;
      de_r <= de_nxt;
      {hsw_s, hbp_s, hact_s, hfp_s} <= {hsw_sn, hbp_sn, hact_sn, hfp_sn};
      {vsw_s, vbp_s, vact_s, vfp_s} <= {vsw_sn, vbp_sn, vact_sn, vfp_sn};
    end
  end

  // pixel word changes with the falling pixel clock, stable at the rising edge
  pvit_pixsrc u_pixsrc (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_tick(tick),
    .i_valid(de_nxt),
    .i_hpos(hcnt_nxt),
    .i_vpos(vcnt_nxt),
    .i_frame(fcnt_r[7:0]),
    .o_pixel_bus(o_pixel_bus_in)
  );

  assign o_hsync = hs_r;
  assign o_vsync = vs_r;
  assign o_pixel_valid_in = de_r;
  assign stat_w = {fcnt_r, 14'h0000, dly_ok, state_r == PVIT_RUN};

  // ---------------- checks ----------------
  logic [CFG_W-1:0] hs_len_r, de_gap_r, line_len_r;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      hs_len_r <= 12'h000;
      de_gap_r <= 12'hFFF;
      line_len_r <= 12'h000;
    end else if (tick) begin
      hs_len_r <= o_hsync ? hs_len_r + 12'h001 : 12'h000;
      // pixel clocks since the last line sync rise, counted apart from the generator
      line_len_r <= (o_hsync && hs_len_r == 12'h000) ? 12'h001 : line_len_r + 12'h001;
      de_gap_r <= o_pixel_valid_in ? 12'h000 :
        (de_gap_r == 12'hFFF ? de_gap_r : de_gap_r + 12'h001);
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_vsync_width: assert property ($fell(o_vsync) |-> vcnt_r >= VSW_MIN)
    else $error("frame sync shorter than one line");
  a_vbp_min: assert property ($rose(o_pixel_valid_in) |-> vcnt_r >= VBP_MIN)
    else $error("active line before vertical back porch");
  a_vblank_total: assert property (state_r == PVIT_RUN |->
    (vfp_s >= VFP_MIN) && (vbp_s + vfp_s >= VBLANK_MIN))
    else $error("vertical blanking too short");
  a_hsync_width: assert property ($fell(o_hsync) |->
    hs_len_r >= HSW_MIN && hs_len_r <= HSW_MAX)
    else $error("line sync width out of range");
  a_hbp_gap: assert property ($rose(o_pixel_valid_in) |-> hcnt_r >= HBP_MIN)
    else $error("valid too soon after line sync");
  a_hfp_gap: assert property ($rose(o_hsync) |-> de_gap_r >= HFP_MIN)
    else $error("line sync too soon after valid");
  a_delay_window: assert property (stat_w[STAT_DLY_OK_BIT] |->
    cfg_r[9] <= VDLY_MAX && cfg_r[9] + VDLY_HI_SUB <= vbp_e && cfg_r[9] + vfp_e >= VDLY_LO_BASE)
    else $error("delay flagged legal outside its window");
  a_pclk_shape: assert property ($rose(o_pclk) |-> o_pclk[*4] ##1 !o_pclk[*4])
    else $error("pixel clock not divided by eight");
  a_out_on_fall: assert property ($changed(o_hsync) || $changed(o_pixel_valid_in) |->
    $fell(o_pclk))
    else $error("port output changed away from falling pixel clock");
  a_hblank_sum: assert property ($rose(o_hsync) && $past(state_r) == PVIT_RUN && !$past(load) |->
    line_len_r - hact_s >= hbp_s + hfp_s && hbp_s >= hsw_s)
    else $error("line blanking below porches");

  c_frame_start: cover property ($rose(o_vsync));
  c_active_pixel: cover property ($rose(o_pixel_valid_in) ##[1:40] $fell(o_pixel_valid_in));
  c_stop: cover property (state_r == PVIT_RUN ##1 state_r == PVIT_IDLE);
endmodule

//--- verif/pvit_sink_model.sv
// video sink model: samples the port at pixel clock rise and measures its timing
`timescale 1ns/1ps
module pvit_sink_model (
  input wire logic i_pclk,
  input wire logic i_vsync,
  input wire logic i_hsync,
  input wire logic i_valid,
  input wire logic [23:0] i_bus,
  output logic [15:0] o_frames,
  output logic [15:0] o_hsw,
  output logic [15:0] o_hbp,
  output logic [15:0] o_hfp,
  output logic [15:0] o_hact,
  output logic [15:0] o_vsw,
  output logic [15:0] o_vbp,
  output logic [15:0] o_vfp,
  output logic [15:0] o_vact,
  output logic [15:0] o_errs,
  output logic [7:0] o_vdly_cfg
);
  logic [7:0] vsync_line_delay_cfg_r = 8'h05;
  logic hs_q = 0, vs_q = 0, dv_q = 0, have = 0, fell = 0;
  logic [15:0] pc = 0, lc = 0, fpc = 0, px = 0, first = 0, last = 0, nact = 0, vswc = 0;
  logic [7:0] lpx = 0;
  assign o_vdly_cfg = vsync_line_delay_cfg_r;
  initial begin
    o_frames = 0;
    o_errs = 0;
  end
  always @(posedge i_pclk) begin
    pc = pc + 1;
    if (i_vsync && !vs_q) begin
      if (have) begin
        o_vsw = vswc;
        o_vbp = first;
        o_vfp = lc - last;
        o_vact = nact;
        if (vswc < 1) o_errs++;
        if (first < 2) o_errs++;
        if (lc - last < 1) o_errs++;
        if (first + lc - last < 12) o_errs++;
      end
      o_frames++;
      have = 1;
      lc = 0;
      nact = 0;
      vswc = 0;
    end else if (i_hsync && !hs_q) begin
      lc++;
    end
    if (i_hsync && !hs_q) begin
      if (fell) begin
        o_hfp = pc - fpc;
        if (o_hfp < 8) o_errs++;
      end
      fell = 0;
      pc = 0;
      if (i_vsync) vswc++;
    end
    if (!i_hsync && hs_q) begin
      o_hsw = pc;
      if (pc < 4 || pc > 128) o_errs++;
    end
    if (i_valid && !dv_q) begin
      o_hbp = pc;
      px = 0;
      if (pc < 4) o_errs++;
      if (nact == 0) first = lc;
      last = lc;
      nact++;
    end
    if (i_valid) begin
      if (dv_q && i_bus[7:0] !== lpx + 8'h01) o_errs++;
      lpx = i_bus[7:0];
      px++;
    end else if (i_bus !== 24'h000000) begin
      o_errs++;
    end
    if (!i_valid && dv_q) begin
      o_hact = px;
      fpc = pc;
      fell = 1;
    end
    hs_q = i_hsync;
    vs_q = i_vsync;
    dv_q = i_valid;
  end
endmodule

//--- verif/test_pvit_top.sv
// testbench of the video source: register access, frame timing and delay window
`timescale 1ns/1ps
module test_pvit_top;
  import pvit_pkg::*;
  logic clk = 0, i_rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [3:0] ws = 0;
  logic awr, wr, bv, arr, rv, pclk, vs, hs, dv;
  logic [1:0] bresp, rresp;
  logic [23:0] pbus;
  logic [15:0] fr, hsw, hbp, hfp, hact, vsw, vbp, vfp, vact, errs;
  logic [7:0] vdly;
  logic [31:0] lfsr = 32'h665BC3C1;
  int miscompares = 0, checks_done = 0;
  logic [11:0] rst_tab[10] = '{RST_CTRL, RST_HACT, RST_HSW, RST_HBP, RST_HFP, RST_VACT,
    RST_VSW, RST_VBP, RST_VFP, RST_VDLY};
  always #2.5 clk = ~clk;
  pvit_top dut (.i_clk_sys(clk), .i_rst(i_rst), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv),
    .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wr), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv), .i_s_axi_bready(br),
    .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rd),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv), .i_s_axi_rready(rr), .o_pclk(pclk),
    .o_vsync(vs), .o_hsync(hs), .o_pixel_valid_in(dv), .o_pixel_bus_in(pbus));
  pvit_sink_model sink (.i_pclk(pclk), .i_vsync(vs), .i_hsync(hs), .i_valid(dv), .i_bus(pbus),
    .o_frames(fr), .o_hsw(hsw), .o_hbp(hbp), .o_hfp(hfp), .o_hact(hact), .o_vsw(vsw),
    .o_vbp(vbp), .o_vfp(vfp), .o_vact(vact), .o_errs(errs), .o_vdly_cfg(vdly));
  function automatic int rnd(input int m);
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return int'(lfsr[15:0]) % m;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("FAIL %s expected %0h seen %0h", nm, exp, seen);
      miscompares++;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [1:0] r);
    logic ad, wdn;
    @(posedge clk);
    awa <= a; wd <= d; ws <= s; awv <= 1; wv <= 1; br <= 1;
    ad = 0;
    wdn = 0;
    while (!(ad && wdn)) begin
      @(posedge clk);
      if (!ad && awr) begin ad = 1; awv <= 0; end
      if (!wdn && wr) begin wdn = 1; wv <= 0; end
    end
    do @(posedge clk); while (!bv);
    r = bresp;
    br <= 0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    ara <= a; arv <= 1; rr <= 1;
    do @(posedge clk); while (!arr);
    arv <= 0;
    do @(posedge clk); while (!rv);
    d = rd;
    r = rresp;
    rr <= 0;
  endtask
  // c: hact hsw hbp hfp vact vsw vbp vfp vdly, written from 0x04 upward
  task automatic run_cfg(input int c[9], input string nm);
    int ehsw, ehbp, ehfp, evsw, evbp, evfp, lo, hi;
    logic [15:0] f0;
    logic [31:0] d;
    logic [1:0] r;
    realtime t0;
    ehsw = c[1] < 4 ? 4 : (c[1] > 128 ? 128 : c[1]);
    ehbp = c[2] > ehsw ? c[2] : ehsw;
    ehfp = c[3] > 8 ? c[3] : 8;
    evsw = c[5] > 1 ? c[5] : 1;
    evbp = c[6] > evsw ? c[6] : (evsw > 2 ? evsw : 2);
    evfp = c[7] > 1 ? c[7] : 1;
    if (evbp + evfp < 12) evfp = 12 - evbp;
    lo = 6 - evfp < 0 ? 0 : 6 - evfp;
    hi = evbp - 2 > 15 ? 15 : evbp - 2;
    for (int i = 0; i < 9; i++) axi_wr(8'h04 + 8'(4 * i), 32'(c[i]), 4'hF, r);
    f0 = fr;
    axi_wr(REG_CTRL_OFS, 32'h1, 4'hF, r);
    @(posedge pclk);
    t0 = $realtime;
    @(posedge pclk);
    check("pclk period ns", 32'(int'($realtime - t0)), 32'(PCLK_DIV * 5));
    check("pclk in range", 32'($realtime - t0 >= 29.85 && $realtime - t0 <= 1000.0), 32'h1);
    while (fr != f0 + 16'h2) @(posedge clk);
    @(posedge hs);
    t0 = $realtime;
    @(posedge hs);
    check("line blanking", 32'(int'(($realtime - t0) / 40.0) - c[0]), 32'(ehbp + ehfp));
    check("hsync width", hsw, ehsw);
    check("h back porch", hbp, ehbp);
    check("h front porch", hfp, ehfp);
    check("active pixels", hact, c[0]);
    check("vsync width", vsw, evsw);
    check("v back porch", vbp, evbp);
    check("v front porch", vfp, evfp);
    check("active lines", vact, c[4]);
    axi_rd(REG_STAT_OFS, d, r);
    check("delay ok and run", d[1:0], {c[8] >= lo && c[8] <= hi, 1'b1});
    axi_wr(REG_CTRL_OFS, 32'h0, 4'hF, r);
    do axi_rd(REG_STAT_OFS, d, r); while (d[STAT_RUN_BIT] !== 1'b0);
    $display("test %s done", nm);
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (12) @(posedge clk);
    i_rst <= 0;
    foreach (rst_tab[i]) begin
      axi_rd(8'(4 * i), d, r);
      check("reset value", d, {20'h0, rst_tab[i]});
    end
    axi_rd(REG_STAT_OFS, d, r);
    check("status after reset", d, 32'h2);
    check("device delay reset", vdly, 8'h05);
    axi_rd(8'h2C, d, r);
    check("unmapped read", {r, d}, {AXI_SLVERR, 32'h0});
    axi_wr(8'h05, 32'h1, 4'hF, r);
    check("unaligned write resp", r, AXI_SLVERR);
    axi_wr(REG_HACT_OFS, 32'hFFFFFFAB, 4'h1, r);
    axi_rd(REG_HACT_OFS, d, r);
    check("byte lane merge", {r, d}, {AXI_OKAY, 32'h2AB});
    $display("test registers done");
    run_cfg('{8, 2, 1, 0, 3, 0, 0, 0, 9}, "minimum clamps");
    run_cfg('{8, 200, 10, 8, 1, 3, 3, 9, 1}, "sync width ceiling");
    for (int k = 0; k < 2; k++) begin
      run_cfg('{4 + rnd(8), 4 + rnd(4), rnd(8), rnd(8), 1 + rnd(2), rnd(3), rnd(4), rnd(4),
        rnd(16)}, "random geometry");
    end
    check("sink rule errors", errs, 32'h0);
    wrap_up;
  end
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    wrap_up;
  end
endmodule
